/* common/mfp_pkg.sv */
// Shared constants and carrier types for the fault status and pause control block
package mfp_pkg;
  // ------------------------------------------------------------------
  // Pause sizing and frame encoding
  // ------------------------------------------------------------------
  localparam int NPRIO = 9;
  localparam int NCLASS = 8;
  localparam int GLOBAL_IDX = 8;
  localparam int QW = 16;
  localparam logic [15:0] OP_PAUSE = 16'h0001;
  localparam logic [15:0] OP_PFC = 16'h0101;
  localparam logic [15:0] TMR_ZERO = 16'h0000;
  localparam logic [15:0] TMR_ONE = 16'h0001;

  // ------------------------------------------------------------------
  // Link fault detection
  // ------------------------------------------------------------------
  localparam logic [2:0] SEQ_THRESH = 3'h4;
  localparam logic [7:0] COL_WINDOW = 8'h80;

  // One received column from the PCS, already classified
  typedef struct packed {
    logic valid;
    logic is_lf;
    logic is_rf;
  } mfp_rx_col_t;

  // User pause controls, one lane per priority, lane 8 global
  typedef struct packed {
    logic [NPRIO-1:0] req;
    logic [NPRIO-1:0] en;
    logic [NPRIO-1:0][QW-1:0] quanta;
    logic [NPRIO-1:0][QW-1:0] refresh;
  } mfp_pause_cfg_t;

  // Pause frame descriptor handed to the transmit MAC
  typedef struct packed {
    logic [15:0] opcode;
    logic [NCLASS-1:0] class_en;
    logic [NCLASS-1:0][QW-1:0] quanta;
  } mfp_pause_frame_t;
endpackage : mfp_pkg

/* verilog/mfp_fault_det.sv */
// Link fault sequence detector for one fault type
`timescale 1ns/100ps
module mfp_fault_det (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Column stream
  input wire logic col_valid,
  input wire logic col_match,
  // Status
  output logic fault_q
);
  logic [2:0] seq_cnt_q;
  logic [7:0] col_cnt_q;

  // ------------------------------------------------------------------
  // Sequence and window counting
  // ------------------------------------------------------------------
  // A match restarts the quiet window; a full quiet window forgets all
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seq_cnt_q <= 3'h0;
      col_cnt_q <= 8'h00;
    end else if (col_valid && col_match) begin
      col_cnt_q <= 8'h00;
      if (seq_cnt_q != mfp_pkg::SEQ_THRESH) seq_cnt_q <= seq_cnt_q + 3'h1;
    end else if (col_valid) begin
      if (col_cnt_q == mfp_pkg::COL_WINDOW - 8'h01) begin
        col_cnt_q <= 8'h00;
        seq_cnt_q <= 3'h0;
      end else begin
        col_cnt_q <= col_cnt_q + 8'h01;
      end
    end
  end

  // Fault held from the threshold match until a quiet window ends
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_q <= 1'b0;
    end else if (col_valid && col_match &&
                 seq_cnt_q == mfp_pkg::SEQ_THRESH - 3'h1) begin
      fault_q <= 1'b1;
    end else if (col_valid && !col_match &&
                 col_cnt_q == mfp_pkg::COL_WINDOW - 8'h01) begin
      fault_q <= 1'b0;
    end
  end

  chk_fault_set_thresh: assert property (@(posedge clk) disable iff (!rst_n)
    col_valid && col_match && seq_cnt_q == mfp_pkg::SEQ_THRESH - 3'h1 |=> fault_q)
    else $error("fault not raised at sequence threshold");
  chk_fault_hold: assert property (@(posedge clk) disable iff (!rst_n)
    fault_q && !(col_valid && col_cnt_q == mfp_pkg::COL_WINDOW - 8'h01) |=> fault_q)
    else $error("fault dropped before quiet window ended");
endmodule : mfp_fault_det

/* verilog/mfp_fault_pause.sv */
// MAC receive fault status and transmit pause request control
//
// Behaviour
// - Local fault is internal OR received fault
// - Remote fault is a level while detected
// - Internal fault follows test, alignment, BER causes
// - Received fault from enough local fault words
// - Each request bit sends its own quanta
// - Bit 8 global pause, others priority pause
// - Enable gates each priority and global separately
// - Resend requeues every active lane, reloads refresh counters
// - Nine 16-bit quanta, index 8 global
// - Controls are plain ports, no register interface
// - Per-lane refresh value sets retransmit interval
`timescale 1ns/100ps
module mfp_fault_pause (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Internal local fault causes
  input wire logic test_pattern_on,
  input wire logic align_lost,
  input wire logic high_ber,
  // Received column stream
  input wire mfp_pkg::mfp_rx_col_t rx_col,
  // Pause controls
  input wire mfp_pkg::mfp_pause_cfg_t pause_cfg,
  input wire logic resend_pause,
  // Pause frame to transmit MAC
  output mfp_pkg::mfp_pause_frame_t pf_q,
  output logic pf_valid_q,
  input wire logic pf_ready,
  // Fault status
  output logic local_fault_q,
  output logic internal_lf_q,
  output logic received_lf_q,
  output logic remote_fault_q
);
  localparam int N = mfp_pkg::NPRIO;
  localparam int G = mfp_pkg::GLOBAL_IDX;

  logic lf_det;
  logic rf_det;
  logic internal_d;
  logic [N-1:0] act;
  logic [N-1:0] req_q;
  logic [N-1:0] expire;
  logic [N-1:0] set_pend;
  logic [N-1:0] sent;
  logic [N-1:0] pend_q;
  logic [N-1:0][15:0] tmr_q;
  logic pf_free;
  logic launch;
  mfp_pkg::mfp_pause_frame_t pf_d;

  // ------------------------------------------------------------------
  // Fault status
  // ------------------------------------------------------------------
  mfp_fault_det u_lf_det (
    .clk(clk),
    .rst_n(rst_n),
    .col_valid(rx_col.valid),
    .col_match(rx_col.is_lf),
    .fault_q(lf_det)
  );

  mfp_fault_det u_rf_det (
    .clk(clk),
    .rst_n(rst_n),
    .col_valid(rx_col.valid),
    .col_match(rx_col.is_rf),
    .fault_q(rf_det)
  );

  // Any live cause keeps the internal fault up
  assign internal_d = test_pattern_on | align_lost | high_ber;

  // All four status levels retimed together so they stay coherent
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      internal_lf_q <= 1'b0;
      received_lf_q <= 1'b0;
      local_fault_q <= 1'b0;
      remote_fault_q <= 1'b0;
    end else begin
      internal_lf_q <= internal_d;
      received_lf_q <= lf_det;
      local_fault_q <= internal_d | lf_det;
      remote_fault_q <= rf_det;
    end
  end

  // ------------------------------------------------------------------
  // Per-lane pause request tracking
  // ------------------------------------------------------------------
  // Controls arrive as direct ports; no register shadow exists
  assign act = pause_cfg.req & pause_cfg.en;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_q <= '0;
    end else begin
      req_q <= act;
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_lane
    // Refresh expires when the countdown steps from one to zero
    assign expire[i] = act[i] && tmr_q[i] == mfp_pkg::TMR_ONE;
    // Resend is taken as a single strobe; holding it just keeps requeuing
    assign set_pend[i] = act[i] && (!req_q[i] || expire[i] || resend_pause);

    // Countdown reloads on send or resend; a zero refresh never repeats
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        tmr_q[i] <= mfp_pkg::TMR_ZERO;
      end else if (!act[i]) begin
        tmr_q[i] <= mfp_pkg::TMR_ZERO;
      end else if (resend_pause || sent[i]) begin
        tmr_q[i] <= pause_cfg.refresh[i];
      end else if (tmr_q[i] != mfp_pkg::TMR_ZERO) begin
        tmr_q[i] <= tmr_q[i] - mfp_pkg::TMR_ONE;
      end
    end

    // Pending flag: a new set wins over the clear from sending
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pend_q[i] <= 1'b0;
      end else if (!pause_cfg.en[i]) begin
        pend_q[i] <= 1'b0;
      end else if (set_pend[i]) begin
        pend_q[i] <= 1'b1;
      end else if (sent[i]) begin
        pend_q[i] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Frame scheduling
  // ------------------------------------------------------------------
  // A new frame loads only once the one in flight is taken
  assign pf_free = !pf_valid_q || pf_ready;
  assign launch = pf_free && (pend_q != '0);

  // Global goes first; all pending priorities share one PFC frame
  always_comb begin
    sent = '0;
    pf_d = '0;
    if (launch && pend_q[G]) begin
      sent[G] = 1'b1;
      pf_d.opcode = mfp_pkg::OP_PAUSE;
      pf_d.quanta[0] = pause_cfg.quanta[G];
    end else if (launch) begin
      sent = pend_q;
      pf_d.opcode = mfp_pkg::OP_PFC;
      for (int c = 0; c < mfp_pkg::NCLASS; c++) begin
        pf_d.class_en[c] = pend_q[c];
        pf_d.quanta[c] = pend_q[c] ? pause_cfg.quanta[c] : mfp_pkg::TMR_ZERO;
      end
    end
  end

  // Descriptor stands until the transmit MAC accepts it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pf_valid_q <= 1'b0;
      pf_q <= '0;
    end else if (launch) begin
      pf_valid_q <= 1'b1;
      pf_q <= pf_d;
    end else if (pf_ready) begin
      pf_valid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  chk_local_fault_or: assert property (@(posedge clk) disable iff (!rst_n)
    local_fault_q == (internal_lf_q | received_lf_q))
    else $error("local fault differs from its two sources");
  // Both levels checked, so a stuck-high status is caught as well as a missing one
  chk_remote_fault_lvl: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> remote_fault_q == $past(rf_det))
    else $error("remote fault does not follow its detector");
  chk_internal_cause: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> internal_lf_q == ($past(test_pattern_on) || $past(align_lost)
      || $past(high_ber)))
    else $error("internal fault does not follow its causes");
  chk_received_follow: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> received_lf_q == $past(lf_det))
    else $error("received fault does not follow its detector");
  chk_new_req_pending: assert property (@(posedge clk) disable iff (!rst_n)
    act[G] && !req_q[G] |=> pend_q[G] || (pf_valid_q && pf_q.opcode == mfp_pkg::OP_PAUSE))
    else $error("global request did not queue a frame");
  chk_global_opcode: assert property (@(posedge clk) disable iff (!rst_n)
    launch && pend_q[G] |=> pf_valid_q && pf_q.opcode == mfp_pkg::OP_PAUSE
      && pf_q.quanta[0] == $past(pause_cfg.quanta[G]))
    else $error("global frame wrongly formed");
  chk_pfc_opcode: assert property (@(posedge clk) disable iff (!rst_n)
    launch && !pend_q[G] |=> pf_q.opcode == mfp_pkg::OP_PFC
      && pf_q.class_en == $past(pend_q[7:0]))
    else $error("priority frame wrongly formed");
  chk_enable_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (pend_q & ~pause_cfg.en) == '0 ##1 1'b1 |-> (pend_q & ~$past(pause_cfg.en)) == '0)
    else $error("disabled lane still pending");
  chk_resend_reload: assert property (@(posedge clk) disable iff (!rst_n)
    resend_pause && act[0] |=> pend_q[0] && tmr_q[0] == $past(pause_cfg.refresh[0]))
    else $error("resend did not requeue and reload");
  chk_frame_hold: assert property (@(posedge clk) disable iff (!rst_n)
    pf_valid_q && !pf_ready |=> pf_valid_q && $stable(pf_q))
    else $error("descriptor changed before acceptance");

  cov_global_sent: cover property (@(posedge clk) disable iff (!rst_n)
    pf_valid_q && pf_ready && pf_q.opcode == mfp_pkg::OP_PAUSE);
  cov_pfc_sent: cover property (@(posedge clk) disable iff (!rst_n)
    pf_valid_q && pf_ready && pf_q.opcode == mfp_pkg::OP_PFC);
  cov_refresh_fire: cover property (@(posedge clk) disable iff (!rst_n) expire != '0);
  cov_both_faults: cover property (@(posedge clk) disable iff (!rst_n)
    local_fault_q && remote_fault_q);
endmodule : mfp_fault_pause

/* dv/mfp_mac_model.sv */
// Transmit MAC stand-in that takes pause frame descriptors
`timescale 1ns/100ps
module mfp_mac_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Stall control
  input wire logic slow,
  // Descriptor port
  input wire mfp_pkg::mfp_pause_frame_t pf,
  input wire logic pf_valid,
  output logic pf_ready,
  // Capture
  output int n_frames,
  output mfp_pkg::mfp_pause_frame_t last
);
  int seed = 7;
  initial pf_ready = 1'b0;
  // Ready moves off the sampling edge; random stalls stress the hold
  always @(negedge clk) begin
    pf_ready <= slow ? 1'($random(seed)) : 1'b1;
  end
  // A descriptor counts only at an edge where both sides agree
  always @(posedge clk) begin
    if (!rst_n) begin
      n_frames <= 0;
    end else if (pf_valid && pf_ready) begin
      n_frames <= n_frames + 1;
      last <= pf;
    end
  end
endmodule : mfp_mac_model

/* dv/tb_mfp_fault_pause.sv */
// Self-checking bench for fault status and pause control
`timescale 1ns/100ps
module tb_mfp_fault_pause;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] cause = 3'h0;
  mfp_pkg::mfp_rx_col_t col = '0;
  mfp_pkg::mfp_pause_cfg_t cfg = '0;
  logic resend = 1'b0;
  logic slow = 1'b0;
  mfp_pkg::mfp_pause_frame_t pf;
  mfp_pkg::mfp_pause_frame_t last;
  logic pf_valid, pf_ready, lf, ilf, rlf, rf;
  logic [8:0] m;
  int n_frames;
  int errors = 0;
  int samples_checked = 0;
  int seed = 52523;

  initial forever #25 clk = ~clk;

  mfp_fault_pause uut (.clk(clk), .rst_n(rst_n), .test_pattern_on(cause[2]),
    .align_lost(cause[1]), .high_ber(cause[0]), .rx_col(col), .pause_cfg(cfg),
    .resend_pause(resend), .pf_q(pf), .pf_valid_q(pf_valid), .pf_ready(pf_ready),
    .local_fault_q(lf), .internal_lf_q(ilf), .received_lf_q(rlf), .remote_fault_q(rf));

  mfp_mac_model mac (.clk(clk), .rst_n(rst_n), .slow(slow), .pf(pf), .pf_valid(pf_valid),
    .pf_ready(pf_ready), .n_frames(n_frames), .last(last));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic check(input string name, input logic [151:0] seen, input logic [151:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Expected descriptor for a set of pending lanes
  function automatic mfp_pkg::mfp_pause_frame_t exp_frame(input logic [8:0] lanes);
    exp_frame = '0;
    if (lanes[8]) begin
      exp_frame.opcode = mfp_pkg::OP_PAUSE;
      exp_frame.quanta[0] = cfg.quanta[8];
    end else begin
      exp_frame.opcode = mfp_pkg::OP_PFC;
      exp_frame.class_en = lanes[7:0];
      for (int c = 0; c < 8; c++) if (lanes[c]) exp_frame.quanta[c] = cfg.quanta[c];
    end
  endfunction : exp_frame

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Columns with random invalid gaps, whose payload must be ignored
  task automatic send_cols(input int n, input logic l, input logic r);
    repeat (n) begin
      if (1'($random(seed))) begin
        col <= {1'b0, 2'($random(seed))};
        @(negedge clk);
      end
      col <= {1'b1, l, r};
      @(negedge clk);
    end
    col <= '0;
  endtask : send_cols

  // Set on the fourth column, clear on the 128th quiet one
  task automatic fault_seq(input logic l, input logic r);
    send_cols(3, l, r);
    check("rx fault early", 152'({rlf, rf}), 152'(2'b00));
    send_cols(1, l, r);
    cyc(1);
    check("rx fault set", 152'({rlf, rf, lf}), 152'({l, r, l}));
    send_cols(127, 1'b0, 1'b0);
    check("rx fault hold", 152'({rlf, rf}), 152'({l, r}));
    send_cols(1, 1'b0, 1'b0);
    cyc(1);
    check("rx fault clear", 152'({rlf, rf, lf}), 152'(3'b000));
  endtask : fault_seq

  task automatic wait_frame(input mfp_pkg::mfp_pause_frame_t exp, input string name);
    int n0;
    n0 = n_frames;
    for (int k = 0; k < 200 && n_frames == n0; k++) @(negedge clk);
    check({name, " count"}, 152'(n_frames), 152'(n0 + 1));
    check(name, last, exp);
  endtask : wait_frame

  task automatic pulse_resend;
    resend = 1'b1;
    cyc(1);
    resend = 1'b0;
  endtask : pulse_resend

  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // Hang guard at 20000 cycles, well beyond the several hundred cycles a normal run needs
  initial begin
    #(20000 * 50);
    errors++;
    finish_test;
  end

  // Main sequence
  initial begin
    for (int i = 0; i < 9; i++) cfg.quanta[i] = 16'($random(seed));
    cfg.en = 9'h1FF;
    cyc(6);
    check("reset outs", 152'({pf_valid, lf, ilf, rlf, rf}), 152'(5'h00));
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      cause = 3'(i);
      cyc(1);
      check("internal fault", 152'({ilf, lf}), 152'({2{i != 0}}));
    end
    cause = 3'h0;
    cyc(1);
    fault_seq(1'b1, 1'b0);
    fault_seq(1'b0, 1'b1);
    slow = 1'b1;
    cfg.req[8] = 1'b1;
    wait_frame(exp_frame(9'h100), "global frame");
    m = {1'b0, 8'($random(seed)) | 8'h01};
    cfg.en = {1'b1, 8'($random(seed)) | 8'h01};
    m = m & cfg.en;
    cfg.req = cfg.req | {1'b0, 8'($random(seed))} | m;
    wait_frame(exp_frame(cfg.req & cfg.en & 9'h0FF), "pfc frame");
    m = cfg.req & cfg.en & 9'h0FF;
    cyc(40);
    check("held no repeat", 152'(pf_valid), 152'(0));
    pulse_resend;
    wait_frame(exp_frame(9'h100), "resend global");
    wait_frame(exp_frame(m), "resend pfc");
    cfg.refresh[8] = 16'h0014;
    pulse_resend;
    wait_frame(exp_frame(9'h100), "timed global");
    wait_frame(exp_frame(m), "timed pfc");
    wait_frame(exp_frame(9'h100), "refresh global");
    cfg.en = 9'h000;
    m = 9'(n_frames);
    cyc(60);
    check("disabled quiet", 152'(n_frames), 152'(m));
    finish_test;
  end
endmodule : tb_mfp_fault_pause
